/* verilog/tpcs_top.v */
/*
 * shared prescaler and count clock selection for two timers, with an
 * axi4-lite register slave holding the prescaler reset bit and selects.
 * assumes a single 20 mhz mclk, asynchronous active-high reset, and
 * pin inputs already synchronous-sampled by the pin logic here.
 */
// Functional notes
// RL1 - select value 1 clocks the timer on every system clock cycle.
// RL2 - the prescaler gives taps at clock divided by 8, 64, 256 and 1024.
// RL3 - the prescaler runs freely and is shared, each timer picks its own.
// RL4 - enabling a prescaled select gives a first count in 1 to N+1 cycles.
// RL5 - a prescaler reset restarts the period for both timers.
// RL6 - the count pin is sampled every cycle and then edge detected.
// RL7 - sampling registers use the rising clock, after a latch stage; here a rising-edge flip-flop stands in for the latch.
// RL8 - select 7 counts rising pin edges, select 6 counts falling edges.
// RL9 - pin edge to counter update takes between 2.5 and 3.5 cycles.
// RL10 - the pin must be stable a cycle when external clocking is toggled.
// RL11 - each external half period must exceed one system clock cycle.
// RL12 - the external clock should stay below system clock over 2.5.
// RL13 - the external pin edges are never passed through the prescaler.
// RL14 - writing one to bit 0 resets the prescaler, then hardware clears it.
// RL15 - writing zero to bit 0 does nothing and bit 0 always reads zero.
// RL16 - select value 0 stops the count clock, the counter stays readable.
// RL17 - selects 2 to 5 pick /8 to /1024, prescaler is a 10-bit counter.
`timescale 1ns/1ns
`default_nettype none
`include "tpcs_map.vh"

module tpcs_top #(
  parameter PRESC_WIDTH = 10
)
(
  input wire mclk,
  input wire reset,
  input wire [3:0] s_axi_awaddr,
  input wire s_axi_awvalid,
  output wire s_axi_awready,
  input wire [31:0] s_axi_wdata,
  input wire [3:0] s_axi_wstrb,
  input wire s_axi_wvalid,
  output wire s_axi_wready,
  output reg [1:0] s_axi_bresp,
  output reg s_axi_bvalid,
  input wire s_axi_bready,
  input wire [3:0] s_axi_araddr,
  input wire s_axi_arvalid,
  output wire s_axi_arready,
  output reg [31:0] s_axi_rdata,
  output reg [1:0] s_axi_rresp,
  output reg s_axi_rvalid,
  input wire s_axi_rready,
  input wire external_count_pin0,
  input wire external_count_pin1,
  output wire timer0_count_clock,
  output wire timer1_count_clock
);

  // ****************************************************
  // registers
  // ****************************************************
  reg [7:0] special_function_io;
  reg [2:0] timer0_count_clock_select;
  reg [2:0] timer1_count_clock_select;
  reg aw_held;
  reg w_held;
  reg [3:0] aw_addr;
  reg [31:0] w_data;
  reg [3:0] w_strb;
  wire do_write;
  wire psr_pulse;
  wire [3:0] tap;
  wire [PRESC_WIDTH-1:0] presc_count;
  reg [31:0] next_rdata;
  reg next_rerr;

  // ****************************************************
  // write channel capture
  // ****************************************************
  // address and data are taken in either order, then one write fires
  assign s_axi_awready = ~aw_held & ~s_axi_bvalid;
  assign s_axi_wready = ~w_held & ~s_axi_bvalid;
  assign do_write = aw_held & w_held & ~s_axi_bvalid;

  always @(posedge mclk or posedge reset)
  begin
    if (reset)
    begin
      aw_held <= 1'b0;
      w_held <= 1'b0;
      aw_addr <= 4'h0;
      w_data <= 32'h0;
      w_strb <= 4'h0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= `TPCS_RESP_OKAY;
    end
    else
    begin
      if (s_axi_awvalid & s_axi_awready)
      begin
        aw_held <= 1'b1;
        aw_addr <= s_axi_awaddr;
      end
      if (s_axi_wvalid & s_axi_wready)
      begin
        w_held <= 1'b1;
        w_data <= s_axi_wdata;
        w_strb <= s_axi_wstrb;
      end
      if (do_write)
      begin
        aw_held <= 1'b0;
        w_held <= 1'b0;
        s_axi_bvalid <= 1'b1;
        if (aw_addr == `TPCS_OFS_SFIO || aw_addr == `TPCS_OFS_SEL)
          s_axi_bresp <= `TPCS_RESP_OKAY;
        else if (aw_addr == `TPCS_OFS_PRESC)
          s_axi_bresp <= `TPCS_RESP_OKAY;
        else
          s_axi_bresp <= `TPCS_RESP_SLVERR;
      end
      else if (s_axi_bvalid & s_axi_bready)
        s_axi_bvalid <= 1'b0;
    end
  end

  // ****************************************************
  // register writes
  // ****************************************************
  // psr bit self-clears the cycle after it was set, so it is a pulse
  always @(posedge mclk or posedge reset)
  begin
    if (reset)
    begin
      special_function_io <= `TPCS_SFIO_RESET;
      timer0_count_clock_select <= `TPCS_SEL_RESET;
      timer1_count_clock_select <= `TPCS_SEL_RESET;
    end
    else
    begin
      special_function_io[`TPCS_PSR_BIT] <= 1'b0; // RL14
      if (do_write && aw_addr == `TPCS_OFS_SFIO && w_strb[0])
      begin
        // writing zero to the reset bit leaves it clear: no effect
        special_function_io[7:1] <= w_data[7:1];
        special_function_io[`TPCS_PSR_BIT] <=
          w_data[`TPCS_PSR_BIT]; // RL14 RL15
      end
      if (do_write && aw_addr == `TPCS_OFS_SEL && w_strb[0])
      begin
        timer0_count_clock_select <= w_data[`TPCS_SEL_T0_LSB +: 3];
        timer1_count_clock_select <= w_data[`TPCS_SEL_T1_LSB +: 3];
      end
    end
  end

  assign psr_pulse = special_function_io[`TPCS_PSR_BIT]; // RL14

  // ****************************************************
  // read channel
  // ****************************************************
  assign s_axi_arready = ~s_axi_rvalid;

  // reset bit reads zero whatever its internal state
  always @*
  begin
    next_rdata = 32'h0;
    next_rerr = 1'b0;
    if (s_axi_araddr == `TPCS_OFS_SFIO)
      next_rdata[7:0] = {special_function_io[7:1], 1'b0}; // RL15
    else if (s_axi_araddr == `TPCS_OFS_SEL)
    begin
      next_rdata[`TPCS_SEL_T0_LSB +: 3] = timer0_count_clock_select;
      next_rdata[`TPCS_SEL_T1_LSB +: 3] = timer1_count_clock_select;
    end
    else if (s_axi_araddr == `TPCS_OFS_PRESC)
      next_rdata[PRESC_WIDTH-1:0] = presc_count;
    else
      next_rerr = 1'b1;
  end

  always @(posedge mclk or posedge reset)
  begin
    if (reset)
    begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0;
      s_axi_rresp <= `TPCS_RESP_OKAY;
    end
    else if (s_axi_arvalid & s_axi_arready)
    begin
      s_axi_rvalid <= 1'b1;
      s_axi_rdata <= next_rdata;
      s_axi_rresp <= next_rerr ? `TPCS_RESP_SLVERR : `TPCS_RESP_OKAY;
    end
    else if (s_axi_rvalid & s_axi_rready)
      s_axi_rvalid <= 1'b0;
  end

  // ****************************************************
  // prescaler and per-timer selection
  // ****************************************************
  // one shared prescaler; both selectors see the same taps
  tpcs_prescaler #(
    .WIDTH(PRESC_WIDTH)
  ) u_presc (
    .mclk(mclk),
    .reset(reset),
    .clear(psr_pulse), // RL5
    .tap(tap),
    .count(presc_count)
  );

  tpcs_clock_select u_sel0 (
    .mclk(mclk),
    .reset(reset),
    .count_clock_select(timer0_count_clock_select),
    .tap(tap),
    .external_count_pin(external_count_pin0),
    .timer_count_clock(timer0_count_clock)
  );

  tpcs_clock_select u_sel1 (
    .mclk(mclk),
    .reset(reset),
    .count_clock_select(timer1_count_clock_select),
    .tap(tap),
    .external_count_pin(external_count_pin1),
    .timer_count_clock(timer1_count_clock)
  );

endmodule
`default_nettype wire

/* verilog/tpcs_map.vh */
/*
 * register offsets, field positions, reset values and tap divisors for the
 * shared timer prescaler and count clock select block.
 * assumes inclusion from the plain verilog-2005 design files and the systemverilog bench.
 */
`ifndef TPCS_MAP_VH
`define TPCS_MAP_VH

// ****************************************************
// register byte offsets on the axi4-lite slave
// ****************************************************
`define TPCS_OFS_SFIO 4'h0
`define TPCS_OFS_SEL 4'h4
`define TPCS_OFS_PRESC 4'h8

// ****************************************************
// field positions and reset values
// ****************************************************
`define TPCS_PSR_BIT 0
`define TPCS_SFIO_RESET 8'h00
`define TPCS_SEL_T0_LSB 0
`define TPCS_SEL_T1_LSB 4
`define TPCS_SEL_RESET 3'h0

// ****************************************************
// clock select encodings
// ****************************************************
`define TPCS_CS_STOP 3'h0
`define TPCS_CS_DIRECT 3'h1
`define TPCS_CS_DIV8 3'h2
`define TPCS_CS_DIV64 3'h3
`define TPCS_CS_DIV256 3'h4
`define TPCS_CS_DIV1024 3'h5
`define TPCS_CS_FALL 3'h6
`define TPCS_CS_RISE 3'h7

// ****************************************************
// prescaler tap masks (count low bits all ones)
// ****************************************************
`define TPCS_TAP8 3'h7
`define TPCS_TAP64 6'h3f
`define TPCS_TAP256 8'hff
`define TPCS_TAP1024 10'h3ff

// axi response codes
`define TPCS_RESP_OKAY 2'h0
`define TPCS_RESP_SLVERR 2'h2

`endif

/* verilog/tpcs_prescaler.v */
/*
 * free-running 10-bit prescaler shared by both timers, giving one-cycle
 * tap pulses at /8, /64, /256 and /1024.
 * assumes one clock mclk and a synchronous clear from the register file.
 */
`timescale 1ns/1ns
`default_nettype none
`include "tpcs_map.vh"

module tpcs_prescaler #(
  parameter WIDTH = 10
)
(
  input wire mclk,
  input wire reset,
  input wire clear,
  output wire [3:0] tap,
  output wire [WIDTH-1:0] count
);

  reg [WIDTH-1:0] presc;

  // counter runs whatever either timer selects; clear restarts all taps
  always @(posedge mclk or posedge reset)
  begin
    if (reset)
      presc <= {WIDTH{1'b0}};
    else if (clear)
      presc <= {WIDTH{1'b0}}; // RL5
    else
      presc <= presc + 1'b1; // RL3
  end

  // a tap fires in the cycle the low bits roll over, so each timer sees
  // its first count 1..N+1 cycles after selecting the tap
  assign tap[0] = (presc[2:0] == `TPCS_TAP8); // RL2
  assign tap[1] = (presc[5:0] == `TPCS_TAP64); // RL2
  assign tap[2] = (presc[7:0] == `TPCS_TAP256); // RL2
  assign tap[3] = (presc[9:0] == `TPCS_TAP1024); // RL2
  assign count = presc;

endmodule
`default_nettype wire

/* verilog/tpcs_clock_select.v */
/*
 * per-timer count clock select: stop, direct, four taps, or external pin
 * edges through a synchroniser and edge detector.
 * assumes the pin level is synchronous-sampled against mclk.
 */
`timescale 1ns/1ns
`default_nettype none
`include "tpcs_map.vh"

module tpcs_clock_select (
  input wire mclk,
  input wire reset,
  input wire [2:0] count_clock_select,
  input wire [3:0] tap,
  input wire external_count_pin,
  output reg timer_count_clock
);

  reg sync_a;
  reg sync_b;
  reg edge_prev;
  reg next_clock;

  // ****************************************************
  // pin sampling
  // ****************************************************
  // the first stage stands in for the transparent-high latch; only
  // sync_b reads it, so metastability never reaches the edge detector
  always @(posedge mclk or posedge reset)
  begin
    if (reset)
    begin
      sync_a <= 1'b0;
      sync_b <= 1'b0;
      edge_prev <= 1'b0;
    end
    else
    begin
      sync_a <= external_count_pin; // RL6 RL7
      sync_b <= sync_a; // RL7
      edge_prev <= sync_b; // RL6
    end
  end

  // ****************************************************
  // source mux
  // ****************************************************
  // external edges bypass the taps entirely
  always @*
  begin
    case (count_clock_select)
      `TPCS_CS_STOP: next_clock = 1'b0; // RL16
      `TPCS_CS_DIRECT: next_clock = 1'b1; // RL1
      `TPCS_CS_DIV8: next_clock = tap[0]; // RL17
      `TPCS_CS_DIV64: next_clock = tap[1]; // RL17
      `TPCS_CS_DIV256: next_clock = tap[2]; // RL17
      `TPCS_CS_DIV1024: next_clock = tap[3]; // RL4
      `TPCS_CS_FALL: next_clock = edge_prev & ~sync_b; // RL8 RL13
      default: next_clock = sync_b & ~edge_prev; // RL8 RL13
    endcase
  end

  // registered pulse: pin edge to count enable lands 3 edges later (RL9)
  always @(posedge mclk or posedge reset)
  begin
    if (reset)
      timer_count_clock <= 1'b0;
    else
      timer_count_clock <= next_clock; // RL9
  end

endmodule
`default_nettype wire

/* tb/tpcs_pin_source.sv */
/* external count source driving both count pins with one waveform.
   assumes mclk from the bench; the pins stand still while run is low. */
`timescale 1ns/1ns
`default_nettype none
module tpcs_pin_source (
  input wire logic mclk,
  input wire logic run,
  input wire logic slow,
  output var logic pin0,
  output wire logic pin1
);
  // ****************
  // toggling source
  // ****************
  int ticks = 0;
  initial pin0 = 1'b0;
  assign pin1 = pin0;
  // half period of 3 or 7 cycles stays under mclk/2.5 with margin
  always @(posedge mclk)
  begin
    if (run)
    begin
      ticks <= (ticks >= (slow ? 6 : 2)) ? 0 : ticks + 1;
      if (ticks >= (slow ? 6 : 2))
        pin0 <= !pin0;
    end
  end
endmodule
`default_nettype wire

/* tb/tpcs_top_properties.sv */
/* port assertions for the prescaler and count clock select top.
   assumes a bind onto tpcs_top, one clock mclk, active-high reset. */
`timescale 1ns/1ns
`default_nettype none
module tpcs_checker (
  input wire mclk,
  input wire reset,
  input wire [3:0] s_axi_awaddr,
  input wire s_axi_awvalid,
  input wire s_axi_awready,
  input wire [31:0] s_axi_wdata,
  input wire s_axi_wvalid,
  input wire s_axi_wready,
  input wire s_axi_bvalid,
  input wire [3:0] s_axi_araddr,
  input wire s_axi_arvalid,
  input wire s_axi_arready,
  input wire [31:0] s_axi_rdata,
  input wire [1:0] s_axi_rresp,
  input wire s_axi_rvalid,
  input wire external_count_pin0,
  input wire external_count_pin1,
  input wire timer0_count_clock,
  input wire timer1_count_clock
);
  // ****************
  // select shadow
  // ****************
  reg [3:0] aq;
  reg [3:0] rq;
  reg [7:0] wq;
  reg [7:0] sel;
  reg bq;
  wire psr_go;
  wire t0;
  wire t1;
  assign t0 = timer0_count_clock;
  assign t1 = timer1_count_clock;
  assign psr_go = s_axi_bvalid && !bq && aq == 4'h0 && wq[0];
  // updated one edge after the write lands, as the outputs are
  always @(posedge mclk or posedge reset)
  begin
    if (reset)
    begin
      aq <= 4'h0;
      rq <= 4'h0;
      wq <= 8'h00;
      sel <= 8'h00;
      bq <= 1'b0;
    end
    else
    begin
      if (s_axi_awvalid && s_axi_awready)
        aq <= s_axi_awaddr;
      if (s_axi_arvalid && s_axi_arready)
        rq <= s_axi_araddr;
      if (s_axi_wvalid && s_axi_wready)
        wq <= s_axi_wdata[7:0];
      bq <= s_axi_bvalid;
      if (s_axi_bvalid && !bq && aq == 4'h4)
        sel <= wq;
    end
  end
  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (reset);
  a_stop_quiet: assert property (sel[2:0] == 3'h0 |-> !t0)
    else $error("count clock while stopped");
  a_direct_every: assert property (sel[6:4] == 3'h1 |-> t1)
    else $error("direct select missed a cycle");
  a_div8_gap: assert property (t0 && sel[2:0] == 3'h2
    |=> (!t0 || sel[2:0] != 3'h2) [*7])
    else $error("divide by 8 pulses too close");
  a_ext_rise: assert property ($rose(external_count_pin0)
    && sel[2:0] == 3'h7 |-> ##1 (!t0) [*2] ##1 t0)
    else $error("rising pin edge pulse latency wrong");
  a_ext_fall: assert property ($fell(external_count_pin1)
    && sel[6:4] == 3'h6 |-> ##3 t1)
    else $error("falling pin edge pulse missing");
  a_ext_cause: assert property (t0 && sel[2:0] == 3'h7
    |-> $past(external_count_pin0, 3) && !$past(external_count_pin0, 4))
    else $error("external pulse without pin edge");
  a_psr_restart: assert property (psr_go && sel[2:0] == 3'h2
    |-> ##3 (!t0) [*5] ##[1:5] t0)
    else $error("prescaler restart timing wrong");
  a_psr_reads_zero: assert property (s_axi_rvalid && rq == 4'h0
    |-> s_axi_rdata[0] == 1'b0)
    else $error("reset bit read as one");
  a_unmapped_err: assert property (s_axi_rvalid && rq == 4'hc
    |-> s_axi_rresp == 2'h2 && s_axi_rdata == 32'h0)
    else $error("unmapped read not refused");
  c_psr: cover property (psr_go);
  c_rise: cover property (t0 && sel[2:0] == 3'h7);
  c_fall: cover property (t1 && sel[6:4] == 3'h6);
endmodule
bind tpcs_top tpcs_checker chk (.*);
`default_nettype wire

/* tb/tpcs_top_tb.sv */
/* self-checking bench: axi4-lite master, pulse counters, pin source.
   assumes a 20 mhz mclk and the register map of the block's header. */
`timescale 1ns/1ns
`default_nettype none
`include "tpcs_map.vh"
module timer_prescaler_clock_select_tb;
  // ****************
  // stimulus and counters
  // ****************
  logic mclk = 1'b0;
  logic reset = 1'b1;
  logic [3:0] awaddr = 4'h0;
  logic [3:0] araddr = 4'h0;
  logic [31:0] wdata = 32'h0;
  logic [31:0] rd;
  logic awvalid = 1'b0;
  logic wvalid = 1'b0;
  logic bready = 1'b0;
  logic arvalid = 1'b0;
  logic rready = 1'b0;
  logic run = 1'b0;
  logic slow = 1'b0;
  logic pr = 1'b0;
  logic [1:0] rsp;
  wire awready, wready, bvalid, arready, rvalid, pin0, pin1, tc0, tc1;
  wire [1:0] bresp;
  wire [1:0] rresp;
  wire [31:0] rdata;
  int error_cnt = 0;
  int comparisons = 0;
  int cnt0 = 0;
  int cnt1 = 0;
  int rises = 0;
  int falls = 0;
  tpcs_top uut (.mclk(mclk), .reset(reset), .s_axi_awaddr(awaddr),
    .s_axi_awvalid(awvalid), .s_axi_awready(awready),
    .s_axi_wdata(wdata), .s_axi_wstrb(4'hf), .s_axi_wvalid(wvalid),
    .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
    .s_axi_bready(bready), .s_axi_araddr(araddr),
    .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
    .s_axi_rready(rready), .external_count_pin0(pin0),
    .external_count_pin1(pin1), .timer0_count_clock(tc0),
    .timer1_count_clock(tc1));
  tpcs_pin_source src (.mclk(mclk), .run(run), .slow(slow), .pin0(pin0),
    .pin1(pin1));
  initial
    forever #25 mclk = ~mclk;
  // pulses and pin edges, counted on the sampling edge
  always @(posedge mclk)
  begin
    cnt0 <= cnt0 + int'(tc0 === 1'b1);
    cnt1 <= cnt1 + int'(tc1 === 1'b1);
    pr <= pin0;
    rises <= rises + int'(pin0 && !pr);
    falls <= falls + int'(!pin0 && pr);
  end
  task automatic chk(input string what, input logic [31:0] seen, exp);
    comparisons++;
    if (seen !== exp)
    begin
      error_cnt++;
      $display("MISMATCH %s expected %h seen %h", what, exp, seen);
    end
  endtask
  // handshakes judged at the falling edge, where both sides are settled
  task automatic wr(input logic [3:0] a, input logic [31:0] d);
    logic ta, tw;
    @(posedge mclk);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    do
    begin
      @(negedge mclk);
      ta = awready || !awvalid;
      tw = wready || !wvalid;
      @(posedge mclk);
      if (ta)
        awvalid <= 1'b0;
      if (tw)
        wvalid <= 1'b0;
    end
    while (!(ta && tw));
    do @(negedge mclk); while (bvalid !== 1'b1);
    rsp = bresp;
    @(posedge mclk);
    bready <= 1'b0;
  endtask
  task automatic rdreg(input logic [3:0] a);
    @(posedge mclk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do @(negedge mclk); while (arready !== 1'b1);
    @(posedge mclk);
    arvalid <= 1'b0;
    do @(negedge mclk); while (rvalid !== 1'b1);
    rd = rdata;
    rsp = rresp;
    @(posedge mclk);
    rready <= 1'b0;
  endtask
  task automatic first_pulses(output int k0, k1);
    k0 = -1;
    k1 = -1;
    for (int k = 1; k < 1100 && (k0 < 0 || k1 < 0); k++)
    begin
      @(negedge mclk);
      if (tc0 === 1'b1 && k0 < 0)
        k0 = k;
      if (tc1 === 1'b1 && k1 < 0)
        k1 = k;
    end
  endtask
  // ****************
  // scenarios
  // ****************
  task automatic t_regs;
    rdreg(4'h4);
    chk("select reset", rd, 32'h0);
    wr(4'h0, 32'ha5);
    rdreg(4'h0);
    chk("sfio bit0 reads zero", rd, 32'ha4);
    wr(4'hc, 32'h1);
    chk("unmapped write", rsp, `TPCS_RESP_SLVERR);
    rdreg(4'hc);
    chk("unmapped read", rsp, `TPCS_RESP_SLVERR);
    $display("registers done");
  endtask
  task automatic t_rates;
    int n0, n1, k0, k1;
    int div[6] = '{1, 1, 8, 64, 256, 1024};
    for (int s = 0; s < 6; s++)
    begin
      wr(4'h4, 32'h11 * s);
      first_pulses(k0, k1);
      if (s > 1)
        chk("first count in time", k0 > 0 && k0 <= div[s] + 1, 1);
      n0 = cnt0;
      n1 = cnt1;
      repeat (2048) @(negedge mclk);
      chk("timer0 rate", cnt0 - n0, s ? 2048 / div[s] : 0);
      chk("timer1 rate", cnt1 - n1, s ? 2048 / div[s] : 0);
    end
    $display("rates done");
  endtask
  task automatic t_presc;
    int k0, k1;
    wr(4'h4, 32'h32);
    wr(4'h0, 32'h1);
    // skip the one pulse that may still come from the old phase
    @(negedge mclk);
    first_pulses(k0, k1);
    chk("restart first tap", k0, 8);
    chk("shared restart", k1 - k0, 56);
    rdreg(4'h8);
    chk("prescaler count", rd, 32'h41);
    $display("prescaler reset done");
  endtask
  task automatic t_external;
    int a0, a1, ar, af;
    wr(4'h4, 32'h67);
    for (int s = 0; s < 2; s++)
    begin
      @(negedge mclk);
      a0 = cnt0;
      a1 = cnt1;
      ar = rises;
      af = falls;
      @(posedge mclk);
      slow <= s[0];
      run <= 1'b1;
      repeat (80) @(posedge mclk);
      run <= 1'b0;
      repeat (8) @(negedge mclk);
      chk("rise pulses", cnt0 - a0, rises - ar);
      chk("fall pulses", cnt1 - a1, falls - af);
    end
    $display("external done");
  endtask
  task automatic tally_and_finish;
    $display("comparisons %0d mismatches %0d", comparisons, error_cnt);
    if (error_cnt == 0 && comparisons > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask
  initial
  begin
    repeat (12) @(posedge mclk);
    reset <= 1'b0;
    t_regs;
    t_rates;
    t_presc;
    t_external;
    tally_and_finish;
  end
  // about 15k cycles are expected
  initial
  begin
    repeat (40000) @(posedge mclk);
    error_cnt++;
    tally_and_finish;
  end
endmodule
`default_nettype wire
